/* File: verilog/ebce_pkg.sv */
`default_nettype none

package ebce_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  EBCE_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  EBCE_OFF_ADDR    = 8'h04;
  localparam logic [7:0]  EBCE_OFF_LEN     = 8'h08;
  localparam logic [7:0]  EBCE_OFF_DATA    = 8'h0c;
  localparam logic [7:0]  EBCE_OFF_STATUS  = 8'h10;

  localparam int          EBCE_CTRL_START  = 31;
  localparam int          EBCE_ST_BUSY     = 0;
  localparam int          EBCE_ST_TMO      = 1;
  localparam int          EBCE_ST_FMT      = 2;
  localparam int          EBCE_ST_WFULL    = 3;
  localparam int          EBCE_ST_RFULL    = 4;

  localparam logic [31:0] EBCE_RST_WORD    = 32'h0000_0000;
  localparam logic [15:0] EBCE_RST_HALF    = 16'h0000;

  // ****************************************
  // Idle gaps in cycles, non-block length limit in bytes
  // ****************************************
  localparam logic [3:0]  EBCE_GAP_INC_WR  = 4'h3;
  localparam logic [3:0]  EBCE_GAP_INC_RD  = 4'h4;
  localparam logic [3:0]  EBCE_GAP_FAST    = 4'h1;
  localparam logic [3:0]  EBCE_GAP_SLOW    = 4'h2;
  localparam logic [15:0] EBCE_IMM_MAX     = 16'h0004;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [3:0] timeout;
    logic       stretch_timer_enable_n_n;
    logic       swap;
    logic       fast;
    logic       width16;
    logic       mode_ds;
    logic       incr;
    logic       block;
    logic       write;
  } ebce_ctrl_t;

  localparam ebce_ctrl_t EBCE_CTRL_RST = 12'h000;

  // Strobe mode: upper=write_strobe_n, lower=read_strobe_n, dir=high_byte_enable_n
  // Data-strobe mode: upper/lower byte strobes, dir=direction_read_high
  typedef struct packed {
    logic marker;
    logic upper;
    logic lower;
    logic dir;
  } ebce_pins_t;

  localparam ebce_pins_t EBCE_PINS_IDLE = 4'hf;

  typedef enum logic [2:0] {
    S_IDLE,
    S_AREQ,
    S_ADRV,
    S_ALAT,
    S_DATA,
    S_HS,
    S_GAP
  } ebce_state_t;

endpackage

`default_nettype wire

/* File: verilog/ebce_engine.sv */
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module ebce_engine
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  output logic [31:0]               hrdata_o,
  input  wire logic [15:0]          ad_i,
  output logic [15:0]               ad_o,
  output logic                      ad_oe_n_o,
  output ebce_pkg::ebce_pins_t      pins_o,
  input  wire logic                 handshake_i
);
  import ebce_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic              hs_m;
  logic              hs_s;
  logic              hs_d;
  logic [15:0]       ad_m;
  logic [15:0]       ad_s;
  logic              wr_pend;
  logic [7:0]        wr_off;
  ebce_ctrl_t        ctrl;
  logic [15:0]       addr_reg;
  logic [15:0]       len_reg;
  logic [31:0]       wr_buf;
  logic [31:0]       rd_buf;
  logic              start_q;
  logic              wr_full;
  logic              rd_full;
  logic              tmo_flag;
  logic              fmt_flag;
  ebce_state_t       st;
  logic [3:0]        cnt;
  logic [15:0]       taddr;
  logic [1:0]        pos;
  logic [15:0]       rem;
  logic              first;
  logic              u_word;
  logic              u_hi;
  logic              acc;
  logic              rd_clr;
  logic              data_wr;
  logic              a0;
  logic              word_c;
  logic              hi_c;
  logic              rise;
  logic              exp_c;
  logic              fin_c;
  logic [1:0]        nb2;
  logic              dword_end;
  logic              last;
  logic              fmt_bad;
  logic              start_ok;
  logic              addr_new;
  logic [3:0]        gap_len;
  logic [7:0]        wlo;
  logic [7:0]        whi;
  logic [15:0]       data_out;
  logic [31:0]       rd_val;

  function automatic logic [4:0] bsel(input logic [1:0] p, input logic sw);
    return {(sw ? ~p : p), 3'b000};
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      hs_m <= 1'b1;
      hs_s <= 1'b1;
      hs_d <= 1'b1;
    end
    else
    begin
      hs_m <= handshake_i;
      hs_s <= hs_m;
      hs_d <= hs_s;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ad_m <= EBCE_RST_HALF;
      ad_s <= EBCE_RST_HALF;
    end
    else
    begin
      ad_m <= ad_i;
      ad_s <= ad_m;
    end
  end

  // ****************************************
  // Combinational helpers
  // ****************************************
  always_comb
  begin
    acc       = hsel_i & htrans_i[1] & hready_i;
    rd_clr    = acc & ~hwrite_i & (haddr_i[7:0] == EBCE_OFF_DATA);
    data_wr   = wr_pend & (wr_off == EBCE_OFF_DATA);
    a0        = (ctrl.incr | ~ctrl.block) ? taddr[0] : pos[0];
    word_c    = ctrl.width16 & ~a0 & (rem >= 16'h0002);
    hi_c      = ctrl.width16 & a0;
    rise      = hs_s & ~hs_d;
    exp_c     = (cnt >= ctrl.timeout) | (ctrl.mode_ds & ctrl.stretch_timer_enable_n_n);
    fin_c     = ((st == S_DATA) & exp_c & hs_s & ~(ctrl.mode_ds & ctrl.stretch_timer_enable_n_n))
              | ((st == S_HS) & rise);
    nb2       = u_word ? 2'h2 : 2'h1;
    dword_end = (({1'b0, pos} + {1'b0, nb2}) > 3'h3);
    last      = (rem <= {14'h0000, nb2});
    fmt_bad   = (len_reg == EBCE_RST_HALF)
              | (~ctrl.block & (({14'h0000, addr_reg[1:0]} + len_reg) > EBCE_IMM_MAX));
    start_ok  = start_q & (st == S_IDLE) & ~fmt_bad;
    addr_new  = first | ctrl.incr | ~ctrl.block;
    gap_len   = (ctrl.incr | ~ctrl.block) ? (ctrl.write ? EBCE_GAP_INC_WR : EBCE_GAP_INC_RD)
              : (ctrl.fast ? EBCE_GAP_FAST : EBCE_GAP_SLOW);
    wlo       = wr_buf[bsel(pos, ctrl.swap) +: 8];
    whi       = wr_buf[bsel(pos + 2'h1, ctrl.swap) +: 8];
    data_out  = u_word ? {whi, wlo} : (u_hi ? {wlo, 8'h00} : {8'h00, wlo});
    case (haddr_i[7:0])
      EBCE_OFF_CTRL:   rd_val = {20'h00000, ctrl};
      EBCE_OFF_ADDR:   rd_val = {16'h0000, addr_reg};
      EBCE_OFF_LEN:    rd_val = {16'h0000, len_reg};
      EBCE_OFF_DATA:   rd_val = rd_buf;
      EBCE_OFF_STATUS: rd_val = {27'h0000000, rd_full, wr_full, fmt_flag, tmo_flag,
                                 (st != S_IDLE)};
      default:         rd_val = EBCE_RST_WORD;
    endcase
  end

  // ****************************************
  // Bus slave
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wr_pend     <= 1'b0;
      wr_off      <= 8'h00;
      hrdata_o    <= EBCE_RST_WORD;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      wr_pend     <= acc & hwrite_i;
      wr_off      <= haddr_i[7:0];
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (acc & ~hwrite_i)
      begin
        hrdata_o <= rd_val;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ctrl     <= EBCE_CTRL_RST;
      addr_reg <= EBCE_RST_HALF;
      len_reg  <= EBCE_RST_HALF;
      wr_buf   <= EBCE_RST_WORD;
      start_q  <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      if (wr_pend & (st == S_IDLE) & ~start_q)
      begin
        case (wr_off)
          EBCE_OFF_CTRL:
          begin
            ctrl    <= hwdata_i[11:0];
            start_q <= hwdata_i[EBCE_CTRL_START];
          end
          EBCE_OFF_ADDR:   addr_reg <= hwdata_i[15:0];
          EBCE_OFF_LEN:    len_reg  <= hwdata_i[15:0];
          default:         ;
        endcase
      end
      if (data_wr)
      begin
        wr_buf <= hwdata_i;
      end
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wr_full  <= 1'b0;
      rd_full  <= 1'b0;
      tmo_flag <= 1'b0;
      fmt_flag <= 1'b0;
    end
    else
    begin
      if (data_wr)
      begin
        wr_full <= 1'b1;
      end
      else if (fin_c & ctrl.write & (dword_end | last))
      begin
        wr_full <= 1'b0;
      end
      if (fin_c & ~ctrl.write & (dword_end | last))
      begin
        rd_full <= 1'b1;
      end
      else if (rd_clr)
      begin
        rd_full <= 1'b0;
      end
      if ((st == S_DATA) & (cnt == ctrl.timeout) & ~(ctrl.mode_ds & ctrl.stretch_timer_enable_n_n))
      begin
        tmo_flag <= 1'b1;
      end
      else if (wr_pend & (wr_off == EBCE_OFF_STATUS) & hwdata_i[EBCE_ST_TMO])
      begin
        tmo_flag <= 1'b0;
      end
      if (start_q & (st == S_IDLE) & fmt_bad)
      begin
        fmt_flag <= 1'b1;
      end
      else if (wr_pend & (wr_off == EBCE_OFF_STATUS) & hwdata_i[EBCE_ST_FMT])
      begin
        fmt_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read assembly
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rd_buf <= EBCE_RST_WORD;
    end
    else if (fin_c & ~ctrl.write)
    begin
      if (u_word)
      begin
        rd_buf[bsel(pos, ctrl.swap) +: 8]        <= ad_s[7:0];
        rd_buf[bsel(pos + 2'h1, ctrl.swap) +: 8] <= ad_s[15:8];
      end
      else
      begin
        rd_buf[bsel(pos, ctrl.swap) +: 8] <= u_hi ? ad_s[15:8] : ad_s[7:0];
      end
    end
  end

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st        <= S_IDLE;
      cnt       <= 4'h0;
      taddr     <= EBCE_RST_HALF;
      pos       <= 2'h0;
      rem       <= EBCE_RST_HALF;
      first     <= 1'b0;
      u_word    <= 1'b0;
      u_hi      <= 1'b0;
      pins_o    <= EBCE_PINS_IDLE;
      ad_o      <= EBCE_RST_HALF;
      ad_oe_n_o <= 1'b1;
    end
    else if (fin_c)
    begin
      pins_o    <= EBCE_PINS_IDLE;
      ad_oe_n_o <= 1'b1;
      rem       <= rem - {14'h0000, nb2};
      pos       <= pos + nb2;
      first     <= 1'b0;
      cnt       <= 4'h0;
      if (ctrl.incr)
      begin
        taddr <= taddr + {14'h0000, nb2};
      end
      st <= last ? S_IDLE : S_GAP;
    end
    else
    begin
      case (st)
        S_IDLE:
        begin
          if (start_ok)
          begin
            taddr <= addr_reg;
            pos   <= addr_reg[1:0];
            rem   <= len_reg;
            first <= 1'b1;
            st    <= S_AREQ;
          end
        end
        S_AREQ:
        begin
          if ((~ctrl.mode_ds | hs_s) & (ctrl.write ? wr_full : ~rd_full))
          begin
            u_word     <= word_c;
            u_hi       <= hi_c;
            pins_o.dir <= ctrl.mode_ds ? ~ctrl.write : ~(word_c | hi_c);
            if (addr_new)
            begin
              ad_o      <= ctrl.mode_ds ? {taddr[15:1], 1'b0} : taddr;
              ad_oe_n_o <= 1'b0;
              st        <= S_ADRV;
            end
            else
            begin
              st <= S_ALAT;
            end
          end
        end
        S_ADRV:
        begin
          pins_o.marker <= 1'b0;
          st            <= S_ALAT;
        end
        S_ALAT:
        begin
          if (ctrl.mode_ds)
          begin
            pins_o.upper <= ~(u_word | u_hi);
            pins_o.lower <= ~(u_word | ~u_hi);
          end
          else
          begin
            pins_o.upper <= ~ctrl.write;
            pins_o.lower <= ctrl.write;
          end
          ad_o      <= data_out;
          ad_oe_n_o <= ~ctrl.write;
          cnt       <= 4'h0;
          st        <= S_DATA;
        end
        S_DATA:
        begin
          if (cnt != 4'hf)
          begin
            cnt <= cnt + 4'h1;
          end
          if (exp_c)
          begin
            st <= S_HS;
          end
        end
        S_HS:
        begin
          st <= S_HS;
        end
        S_GAP:
        begin
          cnt <= cnt + 4'h1;
          if (cnt >= gap_len - 4'h1)
          begin
            st <= S_AREQ;
          end
        end
        default:
        begin
          st <= S_IDLE;
        end
      endcase
    end
  end

endmodule // ebce_engine

`default_nettype wire

/* File: testbench/ebce_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module ebce_monitor
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 hreadyout_o,
  input  wire logic                 hresp_o,
  input  wire logic [15:0]          ad_o,
  input  wire logic                 ad_oe_n_o,
  input  wire ebce_pkg::ebce_pins_t pins_o,
  input  wire logic                 handshake_i
);
  import ebce_pkg::*;
  // ****************************************
  // Checks
  // ****************************************
  logic act;
  assign act = !pins_o.upper || !pins_o.lower;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> pins_o == EBCE_PINS_IDLE && ad_oe_n_o) else $error("not idle after reset");
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  chk_marker_alone: assert property ($fell(pins_o.marker) |-> !act)
    else $error("address marker with data strobe");
  chk_addr_setup: assert property ($fell(pins_o.marker) |->
    !ad_oe_n_o && $past(!ad_oe_n_o) && $stable(ad_o)) else $error("address not set up");
  chk_addr_driven: assert property (!pins_o.marker && !act |-> !ad_oe_n_o)
    else $error("address phase without drive");
  chk_data_follows: assert property ($fell(pins_o.marker) |=> ##[0:40] act)
    else $error("no data strobe after address");
  chk_end_idle: assert property ($rose(pins_o.upper) || $rose(pins_o.lower) |->
    pins_o == EBCE_PINS_IDLE) else $error("cycle end left pins active");
  chk_hold_low: assert property ((act && !handshake_i) [*4] |=> act)
    else $error("cycle ended while handshake low");
  cov_addr: cover property ($fell(pins_o.marker));
  cov_stretch: cover property ((act && !handshake_i) [*4]);
  cov_end: cover property ($rose(pins_o.lower));
endmodule // ebce_monitor
bind ebce_engine ebce_monitor mon (.ref_clk_i, .rst_i, .hreadyout_o, .hresp_o, .ad_o,
  .ad_oe_n_o, .pins_o, .handshake_i);
`default_nettype wire

/* File: testbench/ebce_target.sv */
`timescale 1ns/10ps
`default_nettype none
module ebce_target
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  input  wire logic [15:0]          ad_o,
  input  wire logic                 ad_oe_n_o,
  input  wire ebce_pkg::ebce_pins_t pins_o,
  input  wire logic [3:0]           slow_i,
  output logic [15:0]               ad_i,
  output logic                      handshake_i
);
  import ebce_pkg::*;
  // ****************************************
  // Target behaviour
  // ****************************************
  logic [15:0] addr, last_wr, last_ad;
  logic [2:0]  pat;
  logic        act, act_q, mk_q;
  int          n_addr, n_data, wlen, hold;
  assign act = !pins_o.upper || !pins_o.lower;
  assign handshake_i = (hold == 0);
  assign ad_i = !ad_oe_n_o ? ad_o : act ? addr ^ 16'ha5c3 : ~last_ad;
  always @(posedge ref_clk_i)
  begin
    last_ad <= ad_i;
    mk_q    <= pins_o.marker;
    act_q   <= act;
    if (hold > 0)
      hold <= hold - 1;
    if (!pins_o.marker && mk_q)
    begin
      addr   <= ad_o;
      n_addr <= n_addr + 1;
    end
    if (act && !act_q)
    begin
      n_data <= n_data + 1;
      pat    <= {pins_o.dir, pins_o.upper, pins_o.lower};
      wlen   <= 1;
      hold   <= 32'(slow_i);
    end
    else if (act)
      wlen <= wlen + 1;
    if (act && !ad_oe_n_o)
      last_wr <= ad_o;
    if (rst_i)
    begin
      hold    <= 0;
      last_ad <= 16'h0000;
    end
  end
endmodule // ebce_target
`default_nettype wire

/* File: testbench/ebce_engine_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module ebce_engine_bench;
  import ebce_pkg::*;
  // ****************************************
  // Harness
  // ****************************************
  logic        ref_clk_i, rst_i, hsel, hwrite, hrdy, hresp, oe_n, hs;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] ad_o, ad_i;
  logic [3:0]  slow;
  ebce_pins_t  pins;
  int          n_errors, compares, na, nd, da, dd;
  ebce_engine dut (.ref_clk_i, .rst_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .ad_i(ad_i), .ad_o(ad_o),
    .ad_oe_n_o(oe_n), .pins_o(pins), .handshake_i(hs));
  ebce_target tgt (.ref_clk_i, .rst_i, .ad_o(ad_o), .ad_oe_n_o(oe_n), .pins_o(pins),
    .slow_i(slow), .ad_i(ad_i), .handshake_i(hs));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    k = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk_i); while (hrdy !== 1'b1 && ++k < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hrdy !== 1'b1 && ++k < 50);
    r = hrdata;
    if (k >= 50)
    begin
      n_errors++;
      finish_test;
    end
  endtask
  task automatic xfer(input logic [11:0] c, input logic [15:0] a, input logic [15:0] n,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] s;
    int k;
    k = 0;
    ahb(1'b1, EBCE_OFF_ADDR, {16'h0, a}, s);
    ahb(1'b1, EBCE_OFF_LEN, {16'h0, n}, s);
    if (c[0])
      ahb(1'b1, EBCE_OFF_DATA, wd, s);
    na = tgt.n_addr;
    nd = tgt.n_data;
    ahb(1'b1, EBCE_OFF_CTRL, {20'h80000, c}, s);
    repeat (2) @(posedge ref_clk_i);
    ahb(1'b0, EBCE_OFF_STATUS, 32'h0, s);
    while (s[EBCE_ST_BUSY] !== 1'b0 && ++k < 200)
      ahb(1'b0, EBCE_OFF_STATUS, 32'h0, s);
    if (k >= 200)
    begin
      n_errors++;
      finish_test;
    end
    ahb(1'b0, EBCE_OFF_DATA, 32'h0, rd);
    da = tgt.n_addr - na;
    dd = tgt.n_data - nd;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] r;
    chk({28'h0, pins}, {28'h0, EBCE_PINS_IDLE});
    chk({31'h0, oe_n}, 32'h1);
    ahb(1'b0, 8'h14, 32'h0, r);
    chk(r, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_strobe;
    logic [31:0] r;
    xfer(12'h311, 16'h0124, 16'h2, 32'h0000beef, r);
    chk(da, 1);
    chk(dd, 1);
    chk(32'(tgt.addr), 32'h124);
    chk(32'(tgt.last_wr), 32'hbeef);
    chk(32'(tgt.pat), 32'h1);
    chk(tgt.wlen, 4);
    xfer(12'h310, 16'h0124, 16'h2, 32'h0, r);
    chk(32'(r[15:0]), 32'ha4e7);
    chk(32'(tgt.pat), 32'h2);
    xfer(12'h300, 16'h0125, 16'h1, 32'h0, r);
    chk(32'(r[15:8]), 32'he6);
    $display("strobe test done");
  endtask
  task automatic t_block;
    logic [31:0] r;
    xfer(12'h023, 16'h0200, 16'h4, 32'h44332211, r);
    chk(da, 1);
    chk(dd, 4);
    chk(32'(tgt.last_wr[7:0]), 32'h44);
    xfer(12'h007, 16'h0300, 16'h2, 32'h00006655, r);
    chk(da, 2);
    chk(dd, 2);
    chk(32'(tgt.addr), 32'h301);
    xfer(12'h043, 16'h0200, 16'h4, 32'h44332211, r);
    chk(da, 1);
    chk(dd, 4);
    chk(32'(tgt.last_wr[7:0]), 32'h11);
    $display("block test done");
  endtask
  task automatic t_data_strobe;
    logic [31:0] r;
    xfer(12'h219, 16'h0124, 16'h2, 32'h0000beef, r);
    chk(32'(tgt.pat), 32'h0);
    chk(tgt.wlen, 3);
    chk(32'(tgt.addr[15:1]), 32'h92);
    xfer(12'h318, 16'h0124, 16'h2, 32'h0, r);
    chk(32'(r[15:0]), 32'ha4e7);
    chk(32'(tgt.pat), 32'h4);
    $display("data strobe test done");
  endtask
  task automatic t_stretch;
    logic [31:0] r;
    slow <= 4'h6;
    xfer(12'h411, 16'h0124, 16'h2, 32'h00001234, r);
    chk({31'h0, tgt.wlen >= 6}, 32'h1);
    xfer(12'h419, 16'h0124, 16'h2, 32'h00001234, r);
    chk({31'h0, tgt.wlen >= 6}, 32'h1);
    chk(dd, 1);
    xfer(12'h499, 16'h0124, 16'h2, 32'h00001234, r);
    chk({31'h0, tgt.wlen >= 6}, 32'h1);
    chk(dd, 1);
    slow <= 4'h0;
    $display("stretch test done");
  endtask
  initial
  begin
    rst_i = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    slow = 4'h0;
    n_errors = 0;
    compares = 0;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset;
    t_strobe;
    t_block;
    t_data_strobe;
    t_stretch;
    finish_test;
  end
endmodule // ebce_engine_bench
`default_nettype wire
